// [common/bitop_pkg.sv]
`default_nettype none

package bitop_pkg;

	// Opcodes handled by this unit.
	localparam logic [7:0] OPC_BIT_OR     = 8'h07;
	localparam logic [7:0] OPC_BIT_BRANCH = 8'h37;

	// Execution lengths in core cycles, counted while busy is high.
	localparam logic [3:0] CYC_BIT_OR     = 4'h6;
	localparam logic [3:0] CYC_BRANCH     = 4'ha;
	localparam logic [3:0] CNT_LAST       = 4'h1;

	// Operand byte layout: register address, bit index, form selector.
	localparam int OPND_REG_HI = 7;
	localparam int OPND_REG_LO = 4;
	localparam int OPND_BIT_HI = 3;
	localparam int OPND_BIT_LO = 1;
	localparam int OPND_SEL    = 0;

	// Form selector values.
	localparam logic SEL_WREG_DST     = 1'b0;
	localparam logic BRANCH_CLEAR_SEL = 1'b0;

	// Flag register bit positions.
	localparam int FLAG_C = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 5;
	localparam int FLAG_V = 4;
	localparam int FLAG_D = 3;
	localparam int FLAG_H = 2;

	// Bit 0 of a register, the fixed partner bit of the OR forms.
	localparam int LSB_POS = 0;

	// Reset values.
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [3:0] NIB_ZERO  = 4'h0;

	typedef enum {ST_IDLE, ST_READ, ST_WAIT} exec_state_t;
	typedef enum logic {KIND_BOR, KIND_BRANCH} op_kind_t;

endpackage

`default_nettype wire

// [rtl/bit_field_alu.sv]
`timescale 1ns/1ps
`default_nettype none

// Combinational bit-OR datapath for both operand forms.
module bit_field_alu
	import bitop_pkg::*;
(
	input  wire logic [7:0] wreg_val_i,  // Working register value.
	input  wire logic [7:0] freg_val_i,  // Full register value.
	input  wire logic [2:0] bit_idx_i,   // Selected bit position.
	input  wire logic       form_sel_i,  // Operand form selector.
	output logic      [7:0] dst_new_o,   // Destination value after the OR.
	output logic            res_bit_o    // Bit that was written.
);

	// The source is only read here; only the destination copy is modified.
	always_comb
	begin
		if (form_sel_i == SEL_WREG_DST)
		begin
			res_bit_o = wreg_val_i[LSB_POS] | freg_val_i[bit_idx_i];
			dst_new_o = wreg_val_i;
			dst_new_o[LSB_POS] = res_bit_o;
		end
		else
		begin
			// Bit b gathers source bit zero.
			res_bit_o = freg_val_i[bit_idx_i] | wreg_val_i[LSB_POS];
			dst_new_o = freg_val_i;
			dst_new_o[bit_idx_i] = res_bit_o;
		end
	end

endmodule

`default_nettype wire

// [rtl/bit_exec_unit.sv]
`timescale 1ns/1ps
`default_nettype none

//Contract
// - Form 0: dst bit0 |= src bit b.
// - Form 1: dst bit b |= src bit0.
// - Other dst bits, source register untouched.
// - Z from result, S cleared, others kept.
// - Three bytes; operand packs reg, bit, selector.
// - Opcode 07, six cycles, selector swaps roles.
// - Three-bit field selects one of eight bits.
// - Bit clear: PC plus signed offset.
// - Bit set: fall through to next instruction.
// - Branch leaves all flags unchanged.
// - Opcode 37, ten cycles, third byte offset.
module bit_exec_unit
	import bitop_pkg::*;
#(
	parameter int PC_W = 16
)
(
	input  wire logic            sys_clk_i,     // Core clock.
	input  wire logic            srst_i,        // Synchronous reset, active high.
	input  wire logic            instr_valid_i, // Instruction bytes present.
	input  wire logic [7:0]      opcode_i,      // First byte.
	input  wire logic [7:0]      operand_i,     // Packed second byte.
	input  wire logic [7:0]      third_i,       // Register address or offset.
	input  wire logic [PC_W-1:0] pc_i,          // Address after the instruction.
	input  wire logic [7:0]      wreg_data_i,   // Working register read data.
	input  wire logic [7:0]      freg_data_i,   // Full register read data.
	input  wire logic [7:0]      flags_i,       // Current flag register.
	output logic      [3:0]      wreg_addr_o,   // Working register read address.
	output logic      [7:0]      freg_addr_o,   // Full register read address.
	output logic                 wr_en_o,       // Register write strobe.
	output logic                 wr_wreg_o,     // Write targets a working register.
	output logic      [7:0]      wr_addr_o,     // Register write address.
	output logic      [7:0]      wr_data_o,     // Register write data.
	output logic                 flags_wr_o,    // Flag write strobe.
	output logic      [7:0]      flags_o,       // New flag value.
	output logic                 pc_load_o,     // Load branch target.
	output logic      [PC_W-1:0] pc_o,          // Branch target.
	output logic                 busy_o,        // Instruction in progress.
	output logic                 done_o,        // Instruction finished.
	output logic                 ignored_o      // Opcode not handled here.
);

	exec_state_t     state, next_state;
	op_kind_t        kind, next_kind;
	logic [3:0]      cnt, next_cnt;
	logic            sel, next_sel;
	logic [2:0]      bit_idx, next_bit_idx;
	logic [PC_W-1:0] target, next_target;
	logic [3:0]      next_wreg_addr;
	logic [7:0]      next_freg_addr, next_wr_addr, next_wr_data, next_flags;
	logic            next_wr_en, next_wr_wreg, next_flags_wr, next_pc_load;
	logic [PC_W-1:0] next_pc;
	logic            next_busy, next_done, next_ignored;
	logic [7:0]      alu_dst;
	logic            alu_bit;
	logic            is_bor, is_bclr;

	// Recognise an opcode byte against one of ours.
	function automatic logic opc_match(input logic [7:0] opc, input logic [7:0] ref_opc);
		opc_match = (opc == ref_opc);
	endfunction

	// Opcode and selector bit decode.
	// The branch-if-set sibling shares the opcode and is refused here.
	always_comb
	begin
		is_bor  = opc_match(opcode_i, OPC_BIT_OR);
		is_bclr = opc_match(opcode_i, OPC_BIT_BRANCH)
			&& (operand_i[OPND_SEL] == BRANCH_CLEAR_SEL);
	end

	bit_field_alu u_alu (
		.wreg_val_i (wreg_data_i),
		.freg_val_i (freg_data_i),
		.bit_idx_i  (bit_idx),
		.form_sel_i (sel),
		.dst_new_o  (alu_dst),
		.res_bit_o  (alu_bit)
	);

	// Sequencer: accept, read and act once, then hold busy for the full length.
	always_comb
	begin
		next_state     = state;
		next_kind      = kind;
		next_cnt       = cnt;
		next_sel       = sel;
		next_bit_idx   = bit_idx;
		next_target    = target;
		next_wreg_addr = wreg_addr_o;
		next_freg_addr = freg_addr_o;
		next_wr_en     = 1'b0;
		next_wr_wreg   = wr_wreg_o;
		next_wr_addr   = wr_addr_o;
		next_wr_data   = wr_data_o;
		next_flags_wr  = 1'b0;
		next_flags     = flags_o;
		next_pc_load   = 1'b0;
		next_pc        = pc_o;
		next_busy      = busy_o;
		next_done      = 1'b0;
		next_ignored   = 1'b0;
		case (state)
			ST_IDLE:
			begin
				if (instr_valid_i && (is_bor || is_bclr))
				begin
					next_wreg_addr = operand_i[OPND_REG_HI:OPND_REG_LO];
					next_bit_idx   = operand_i[OPND_BIT_HI:OPND_BIT_LO];
					next_sel       = operand_i[OPND_SEL];
					next_freg_addr = third_i;
					next_kind  = is_bor ? KIND_BOR : KIND_BRANCH;
					next_cnt   = is_bor ? CYC_BIT_OR : CYC_BRANCH;
					// The offset wraps modulo the PC width; range is software's job.
					next_target = pc_i + PC_W'({{(PC_W-8){third_i[7]}}, third_i});
					next_busy  = 1'b1;
					next_state = ST_READ;
				end
				else if (instr_valid_i)
				begin
					next_ignored = 1'b1;
				end
			end
			ST_READ:
			begin
				next_cnt   = cnt - CNT_LAST;
				next_state = ST_WAIT;
				if (kind == KIND_BOR)
				begin
					next_wr_en   = 1'b1;
					next_wr_wreg = (sel == SEL_WREG_DST);
					next_wr_addr = (sel == SEL_WREG_DST) ? {NIB_ZERO, wreg_addr_o} : freg_addr_o;
					next_wr_data = alu_dst;
					// Flag update.
					// Overflow is left as it was, one legal reading of undefined.
					next_flags_wr        = 1'b1;
					next_flags           = flags_i;
					next_flags[FLAG_Z]   = ~alu_bit;
					next_flags[FLAG_S]   = 1'b0;
				end
				else if (wreg_data_i[bit_idx] == 1'b0)
				begin
					next_pc_load = 1'b1;
					next_pc      = target;
				end
			end
			ST_WAIT:
			begin
				next_cnt = cnt - CNT_LAST;
				if (cnt == CNT_LAST)
				begin
					next_busy  = 1'b0;
					next_done  = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default:
			begin
				next_state = ST_IDLE;
				next_busy  = 1'b0;
			end
		endcase
	end

	// State and output registers.
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			state       <= ST_IDLE;
			kind        <= KIND_BOR;
			cnt         <= NIB_ZERO;
			sel         <= 1'b0;
			bit_idx     <= 3'h0;
			target      <= '0;
			wreg_addr_o <= NIB_ZERO;
			freg_addr_o <= BYTE_ZERO;
			wr_en_o     <= 1'b0;
			wr_wreg_o   <= 1'b0;
			wr_addr_o   <= BYTE_ZERO;
			wr_data_o   <= BYTE_ZERO;
			flags_wr_o  <= 1'b0;
			flags_o     <= BYTE_ZERO;
			pc_load_o   <= 1'b0;
			pc_o        <= '0;
			busy_o      <= 1'b0;
			done_o      <= 1'b0;
			ignored_o   <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			kind        <= next_kind;
			cnt         <= next_cnt;
			sel         <= next_sel;
			bit_idx     <= next_bit_idx;
			target      <= next_target;
			wreg_addr_o <= next_wreg_addr;
			freg_addr_o <= next_freg_addr;
			wr_en_o     <= next_wr_en;
			wr_wreg_o   <= next_wr_wreg;
			wr_addr_o   <= next_wr_addr;
			wr_data_o   <= next_wr_data;
			flags_wr_o  <= next_flags_wr;
			flags_o     <= next_flags;
			pc_load_o   <= next_pc_load;
			pc_o        <= next_pc;
			busy_o      <= next_busy;
			done_o      <= next_done;
			ignored_o   <= next_ignored;
		end
	end

	// Checking helpers: sampled operand bits and busy run length.
	logic       hb_fsrc, hb_wsrc, hb_wlsb, hb_flsb, hb_read_bor, hb_read_br;
	logic [7:0] hb_wkeep, hb_fkeep;
	logic [3:0] run_len;
	always_comb
	begin
		hb_fsrc     = freg_data_i[bit_idx];
		hb_wsrc     = wreg_data_i[bit_idx];
		hb_wlsb     = wreg_data_i[LSB_POS];
		hb_flsb     = freg_data_i[LSB_POS];
		hb_wkeep    = wreg_data_i & ~(8'h01 << LSB_POS);
		hb_fkeep    = freg_data_i & ~(8'h01 << bit_idx);
		hb_read_bor = (state == ST_READ) && (kind == KIND_BOR);
		hb_read_br  = (state == ST_READ) && (kind == KIND_BRANCH);
	end
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || !busy_o)
			run_len <= CNT_LAST;
		else
			run_len <= run_len + CNT_LAST;
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	a_or_to_lsb: assert property (
		hb_read_bor && sel == SEL_WREG_DST |=> wr_en_o && wr_wreg_o
			&& wr_data_o[LSB_POS] == ($past(hb_wlsb) | $past(hb_fsrc)))
		else $error("bit-OR form 0 result bit wrong");
	a_or_to_bitb: assert property (
		hb_read_bor && sel != SEL_WREG_DST |=> wr_en_o && !wr_wreg_o
			&& wr_data_o[bit_idx] == ($past(hb_fsrc) | $past(hb_wlsb)))
		else $error("bit-OR form 1 result bit wrong");
	a_other_bits_kept: assert property (
		hb_read_bor |=> (sel == SEL_WREG_DST)
			? ((wr_data_o & ~(8'h01 << LSB_POS)) == $past(hb_wkeep)
				&& wr_addr_o == {NIB_ZERO, wreg_addr_o})
			: ((wr_data_o & ~(8'h01 << bit_idx)) == $past(hb_fkeep)
				&& wr_addr_o == freg_addr_o))
		else $error("bit-OR disturbed other bits or the source");
	a_or_flags: assert property (
		flags_wr_o |-> !flags_o[FLAG_S]
			&& flags_o[FLAG_Z] == !(wr_wreg_o ? wr_data_o[LSB_POS] : wr_data_o[bit_idx])
			&& flags_o[FLAG_C] == $past(flags_i[FLAG_C])
			&& flags_o[FLAG_D] == $past(flags_i[FLAG_D])
			&& flags_o[FLAG_H] == $past(flags_i[FLAG_H]))
		else $error("bit-OR flag update wrong");
	a_operand_decode: assert property (
		state == ST_IDLE && instr_valid_i && (is_bor || is_bclr) |=>
			wreg_addr_o == $past(operand_i[OPND_REG_HI:OPND_REG_LO])
			&& bit_idx == $past(operand_i[OPND_BIT_HI:OPND_BIT_LO])
			&& freg_addr_o == $past(third_i))
		else $error("operand byte decoded wrongly");
	a_bor_length: assert property (
		state == ST_IDLE && instr_valid_i && is_bor |=> busy_o [*6] ##1 !busy_o && done_o)
		else $error("bit-OR did not take six cycles");
	a_branch_length: assert property (
		done_o && kind == KIND_BRANCH |-> $past(run_len) == CYC_BRANCH)
		else $error("branch did not take ten cycles");
	a_branch_taken: assert property (
		hb_read_br && !hb_wsrc |=> pc_load_o && pc_o == target)
		else $error("clear bit did not branch to target");
	a_branch_fall: assert property (
		hb_read_br && hb_wsrc |=> !pc_load_o ##1 !pc_load_o)
		else $error("set bit branched");
	a_branch_no_flags: assert property (
		kind == KIND_BRANCH && busy_o |-> !flags_wr_o && !wr_en_o)
		else $error("branch touched flags or registers");
	a_set_form_refused: assert property (
		state == ST_IDLE && instr_valid_i && opcode_i == OPC_BIT_BRANCH
			&& operand_i[OPND_SEL] != BRANCH_CLEAR_SEL |=> ignored_o && !busy_o)
		else $error("branch-if-set form was accepted");

endmodule

`default_nettype wire

// [test/reg_file_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Behavioural core register file and flag register on the far side of the unit.
module reg_file_model
(
	input  wire logic       clk_i,       // Core clock.
	input  wire logic [3:0] wreg_addr_i, // Working register read address.
	input  wire logic [7:0] freg_addr_i, // Full register read address.
	input  wire logic       wr_en_i,     // Register write strobe.
	input  wire logic       wr_wreg_i,   // Write goes to a working register.
	input  wire logic [7:0] wr_addr_i,   // Register write address.
	input  wire logic [7:0] wr_data_i,   // Register write data.
	input  wire logic       flags_wr_i,  // Flag write strobe.
	input  wire logic [7:0] flags_i,     // New flag byte.
	output logic      [7:0] wreg_data_o, // Working register read data.
	output logic      [7:0] freg_data_o, // Full register read data.
	output logic      [7:0] flags_o      // Current flag byte.
);
	logic [7:0] wreg [16];
	logic [7:0] freg [256];
	logic [7:0] flags;

	// Reads are combinational, so the unit sees data in the cycle it drives the address.
	assign wreg_data_o = wreg[wreg_addr_i];
	assign freg_data_o = freg[freg_addr_i];
	assign flags_o     = flags;

	// Writes land at the edge that samples the strobe, like the core's file.
	always @(posedge clk_i)
	begin
		if (wr_en_i && wr_wreg_i)
			wreg[wr_addr_i[3:0]] <= wr_data_i;
		if (wr_en_i && !wr_wreg_i)
			freg[wr_addr_i] <= wr_data_i;
		if (flags_wr_i)
			flags <= flags_i;
	end
endmodule

`default_nettype wire

// [test/bit_or_and_bit_branch_exec_test.sv]
`timescale 1ns/1ps
`default_nettype none

module bit_or_and_bit_branch_exec_test;
	import bitop_pkg::*;

	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        valid = 1'b0;
	logic [7:0]  opcode = 8'h00;
	logic [7:0]  operand = 8'h00;
	logic [7:0]  third = 8'h00;
	logic [15:0] pc_in = 16'h0000;
	logic [7:0]  wdat, fdat, flg, fnew, wdata, waddr, faddr;
	logic [3:0]  wa;
	logic [15:0] pc_out, pc_seen;
	logic        wr_en, wr_w, fwr, pc_load, busy, done, ign;
	int          bad_count = 0;
	int          num_checks = 0;
	int          nbusy, nwr, npc, nign, ndone;

	// The 25 MHz core clock.
	always #20 clk = ~clk;

	bit_exec_unit #(.PC_W(16)) u_dut (.sys_clk_i(clk), .srst_i(srst), .instr_valid_i(valid),
		.opcode_i(opcode), .operand_i(operand), .third_i(third), .pc_i(pc_in),
		.wreg_data_i(wdat), .freg_data_i(fdat), .flags_i(flg), .wreg_addr_o(wa),
		.freg_addr_o(faddr), .wr_en_o(wr_en), .wr_wreg_o(wr_w), .wr_addr_o(waddr),
		.wr_data_o(wdata), .flags_wr_o(fwr), .flags_o(fnew), .pc_load_o(pc_load),
		.pc_o(pc_out), .busy_o(busy), .done_o(done), .ignored_o(ign));

	reg_file_model u_model (.clk_i(clk), .wreg_addr_i(wa), .freg_addr_i(faddr),
		.wr_en_i(wr_en), .wr_wreg_i(wr_w), .wr_addr_i(waddr), .wr_data_i(wdata),
		.flags_wr_i(fwr), .flags_i(fnew), .wreg_data_o(wdat), .freg_data_o(fdat),
		.flags_o(flg));

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask

	// Present one instruction, hold valid for hold edges, then tally the pulses seen.
	task automatic run(input logic [7:0] op, opnd, thd, input int hold);
		nbusy = 0; nwr = 0; npc = 0; nign = 0; ndone = 0;
		@(posedge clk);
		valid <= 1'b1; opcode <= op; operand <= opnd; third <= thd; pc_in <= 16'h0100;
		for (int i = 0; i < 14; i++)
		begin
			@(posedge clk);
			if (i == hold - 1)
				valid <= 1'b0;
			#1;
			nbusy += (busy === 1'b1);
			nwr += (wr_en === 1'b1 || fwr === 1'b1);
			npc += (pc_load === 1'b1);
			nign += (ign === 1'b1);
			ndone += (done === 1'b1);
			if (pc_load === 1'b1)
				pc_seen = pc_out;
		end
		if (busy !== 1'b0)
		begin
			$display("CHECK FAILED t=%0t busy got=%h exp=%h", $time, busy, 1'b0);
			bad_count++;
			final_report();
		end
	endtask

	// Form zero over all eight bit positions; the first also keeps valid high through the first two busy cycles.
	task automatic bor_form0();
		for (int b = 0; b < 8; b++)
		begin
			u_model.wreg[3] = 8'hfe;
			u_model.freg[8'h45] = 8'haa;
			u_model.flags = 8'hbc;
			run(OPC_BIT_OR, {4'h3, b[2:0], 1'b0}, 8'h45, (b == 0) ? 3 : 1);
			chk(u_model.wreg[3], {7'h7f, b[0]});
			chk(u_model.freg[8'h45], 8'haa);
			chk(u_model.flags, {1'b1, ~b[0], 6'h1c});
			chk(nbusy[7:0], 8'h06);
			chk({nwr[3:0], ndone[3:0]}, 8'h11);
		end
	endtask

	// Form one: a set destination bit must survive a clear source bit.
	task automatic bor_form1();
		logic [7:0] e;
		for (int b = 0; b < 8; b++)
		begin
			e = 8'h24 | ({7'h00, b[0]} << b);
			u_model.wreg[3] = {7'h7f, b[0]};
			u_model.freg[8'h45] = 8'h24;
			u_model.flags = 8'hbc;
			run(OPC_BIT_OR, {4'h3, b[2:0], 1'b1}, 8'h45, 1);
			chk(u_model.freg[8'h45], e);
			chk(u_model.wreg[3], {7'h7f, b[0]});
			chk(u_model.flags, {1'b1, ~e[b], 6'h1c});
			chk(nbusy[7:0], 8'h06);
		end
	endtask

	// Bit-test branch on one bit of working register 5, which holds 07.
	task automatic branch(input logic [2:0] b, input logic [7:0] off, input logic [15:0] tgt);
		u_model.wreg[5] = 8'h07;
		u_model.flags = 8'hbc;
		pc_seen = 16'h0000;
		run(OPC_BIT_BRANCH, {4'h5, b, 1'b0}, off, 1);
		chk(npc[7:0], {7'h00, ~u_model.wreg[5][b]});
		chk(pc_seen[15:8], tgt[15:8]);
		chk(pc_seen[7:0], tgt[7:0]);
		chk({nwr[3:0], 4'h0}, 8'h00);
		chk(u_model.flags, 8'hbc);
		chk({nbusy[3:0], ndone[3:0]}, 8'ha1);
	endtask

	// Branch-if-set form and an unhandled opcode are both refused.
	task automatic refused();
		run(OPC_BIT_BRANCH, 8'h51, 8'h10, 1);
		chk({nign[3:0], nbusy[3:0]}, 8'h10);
		run(8'h27, 8'h30, 8'h45, 1);
		chk({nign[3:0], nbusy[3:0]}, 8'h10);
	endtask

	// Main sequence: reset, then every scenario.
	initial
	begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		bor_form0();
		bor_form1();
		// Offsets stay within the signed range.
		branch(3'd3, 8'h80, 16'h0080);
		branch(3'd7, 8'h7f, 16'h017f);
		branch(3'd1, 8'h10, 16'h0000);
		refused();
		final_report();
	end
endmodule

`default_nettype wire
